/* File: rtl/eeprom_slave_pkg.sv */
// Purpose: shared types and constants of the serial EEPROM slave front end
// Assumes: one system clock that oversamples the serial bus pins
// Notes: the design's named constants live here; counter steps and checks use literals
`default_nettype none
package eeprom_slave_pkg;
	// Device type nibbles of the select byte
	localparam logic [3:0] TYPE_ARRAY = 4'ha;
	localparam logic [3:0] TYPE_IDPAGE = 4'hb;
	// Bit counter value at the last bit of one byte
	localparam logic [3:0] LAST_BIT = 4'h7;
	// Byte positions in a write: select, two address bytes, then data
	localparam logic [1:0] IDX_SELECT = 2'h0;
	localparam logic [1:0] IDX_DATA = 2'h3;
	// Reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [3:0] CNT_RST = 4'h0;

	typedef enum logic [2:0] {
		S_STANDBY, S_RX, S_ACK_SET, S_ACK_HOLD, S_ACK_END,
		S_TX, S_RACK, S_TX_NEXT
	} state_t;

	// Pin levels that travel together through the synchroniser
	typedef struct packed {
		logic scl;
		logic sda;
		logic [2:0] cs;
		logic wp;
	} pins_t;

	localparam pins_t PINS_RST = '{scl: 1'b1, sda: 1'b1, cs: 3'h0, wp: 1'b0};

	typedef struct packed {
		pins_t meta;
		pins_t sync;
		logic scl_prev;
		logic sda_prev;
		state_t st;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [1:0] bytecnt;
		logic rnw;
		logic ack;
		logic wr_pend;
		logic id_page;
		logic oe_n;
		logic sda_out;
		logic [7:0] rx_byte;
		logic rx_valid;
		logic [1:0] rx_index;
		logic rd_req;
		logic wr_start;
		logic active;
	} state_vec_t;
endpackage : eeprom_slave_pkg
`default_nettype wire

/* File: rtl/eeprom_slave.sv */
// Purpose: two-wire serial slave front end of a serial EEPROM
// Assumes: clk_i far faster than the serial clock; pins are asynchronous
// Notes: resetn_i is the power-on reset; array and address logic sit outside
`default_nettype none
module eeprom_slave (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic chip_select_input_high,
	input wire logic chip_select_input_mid,
	input wire logic chip_select_input_low,
	input wire logic write_protect_input,
	input wire logic write_busy_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_req_o,
	output logic [7:0] rx_byte_o,
	output logic rx_valid_o,
	output logic [1:0] rx_index_o,
	output logic rnw_o,
	output logic id_page_o,
	output logic wr_start_o,
	output logic active_o
);
	eeprom_slave_pkg::state_vec_t q, d;
	eeprom_slave_pkg::pins_t pins;
	logic scl_rise, scl_fall, start_det, stop_det, cs_match;

	////////////////////////////////////////////////////////////////////
	// Pin sampling and bus events

	// Unconnected chip selects are pulled low outside, so a 0 here
	assign pins = '{scl: scl_i, sda: sda_i, wp: write_protect_input,
		cs: {chip_select_input_high, chip_select_input_mid,
		chip_select_input_low}};
	// Edges only from the second stage onward
	assign scl_rise = q.sync.scl & ~q.scl_prev;
	assign scl_fall = ~q.sync.scl & q.scl_prev;
	// Start/stop: data moves while clock stays high
	assign start_det = q.sync.scl & q.scl_prev & q.sda_prev & ~q.sync.sda;
	assign stop_det = q.sync.scl & q.scl_prev & ~q.sda_prev & q.sync.sda;
	// Chip select field sits in b3..b1, next to the bit now arriving
	assign cs_match = (q.shreg[2:0] == q.sync.cs);

	// Only the array and the identification page types are answered
	function automatic logic type_known(input logic [3:0] nib);
		return nib == eeprom_slave_pkg::TYPE_ARRAY ||
			nib == eeprom_slave_pkg::TYPE_IDPAGE;
	endfunction : type_known

	////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		d = q;
		d.meta = pins;
		d.sync = q.meta;
		d.scl_prev = q.sync.scl;
		d.sda_prev = q.sync.sda;
		d.rx_valid = 1'b0;
		d.rd_req = 1'b0;
		d.wr_start = 1'b0;
		d.sda_out = 1'b0;
		if (stop_det && q.st != eeprom_slave_pkg::S_STANDBY) begin
			// Stop right after a written data byte launches the write
			d.wr_start = q.wr_pend && q.st == eeprom_slave_pkg::S_RX;
			d.wr_pend = 1'b0;
			d.st = eeprom_slave_pkg::S_STANDBY;
			d.oe_n = 1'b1;
			d.active = 1'b0;
		end else if (start_det && !write_busy_i) begin
			// Busy write cycle hides every start
			d.st = eeprom_slave_pkg::S_RX;
			d.bitcnt = eeprom_slave_pkg::CNT_RST;
			d.bytecnt = eeprom_slave_pkg::IDX_SELECT;
			d.wr_pend = 1'b0;
			d.oe_n = 1'b1;
			d.active = 1'b1;
		end else begin
			unique case (q.st)
			eeprom_slave_pkg::S_STANDBY: begin
				d.oe_n = 1'b1;
				d.active = 1'b0;
			end
			eeprom_slave_pkg::S_RX: begin
				// Second edge of a new byte: no stop came after the ack
				if (scl_fall) begin
					d.wr_pend = 1'b0;
				end
				if (scl_rise) begin
					d.shreg = {q.shreg[6:0], q.sync.sda};
					d.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt == eeprom_slave_pkg::LAST_BIT) begin
						d.st = eeprom_slave_pkg::S_ACK_SET;
						d.ack = 1'b1;
						if (q.bytecnt == eeprom_slave_pkg::IDX_SELECT) begin
							d.rnw = q.sync.sda;
							d.id_page = q.shreg[6:3] ==
								eeprom_slave_pkg::TYPE_IDPAGE;
							// Foreign device or type: let the bus go
							if (!cs_match || !type_known(q.shreg[6:3])) begin
								d.st = eeprom_slave_pkg::S_STANDBY;
								d.active = 1'b0;
							end
						end else begin
							d.rx_valid = 1'b1;
							d.rx_byte = {q.shreg[6:0], q.sync.sda};
							d.rx_index = q.bytecnt;
							// Protected data bytes are refused
							if (q.bytecnt == eeprom_slave_pkg::IDX_DATA &&
								q.sync.wp) begin
								d.ack = 1'b0;
							end
						end
					end
				end
			end
			eeprom_slave_pkg::S_ACK_SET: begin
				// Data may only move while the clock is low
				if (scl_fall) begin
					d.oe_n = ~q.ack;
					d.st = eeprom_slave_pkg::S_ACK_HOLD;
				end
			end
			eeprom_slave_pkg::S_ACK_HOLD: begin
				if (scl_rise) begin
					d.st = eeprom_slave_pkg::S_ACK_END;
				end
			end
			eeprom_slave_pkg::S_ACK_END: begin
				if (scl_fall) begin
					d.oe_n = 1'b1;
					d.bitcnt = eeprom_slave_pkg::CNT_RST;
					if (q.bytecnt != eeprom_slave_pkg::IDX_DATA) begin
						d.bytecnt = q.bytecnt + 2'h1;
					end
					// Only an accepted write data byte arms the write
					d.wr_pend = q.ack && !q.rnw &&
						q.bytecnt == eeprom_slave_pkg::IDX_DATA;
					if (q.rnw) begin
						d.st = eeprom_slave_pkg::S_TX;
						d.shreg = rd_data_i;
						d.rd_req = 1'b1;
						d.oe_n = rd_data_i[7];
					end else begin
						d.st = eeprom_slave_pkg::S_RX;
					end
				end
			end
			eeprom_slave_pkg::S_TX: begin
				if (scl_fall) begin
					d.bitcnt = q.bitcnt + 4'h1;
					if (q.bitcnt == eeprom_slave_pkg::LAST_BIT) begin
						d.oe_n = 1'b1;
						d.st = eeprom_slave_pkg::S_RACK;
					end else begin
						d.shreg = {q.shreg[6:0], 1'b0};
						d.oe_n = q.shreg[6];
					end
				end
			end
			eeprom_slave_pkg::S_RACK: begin
				// Master's answer sampled in the ninth clock
				if (scl_rise) begin
					d.st = q.sync.sda ? eeprom_slave_pkg::S_STANDBY
						: eeprom_slave_pkg::S_TX_NEXT;
					d.active = ~q.sync.sda;
				end
			end
			eeprom_slave_pkg::S_TX_NEXT: begin
				// Next byte loads on the fall after the master ack
				if (scl_fall) begin
					d.st = eeprom_slave_pkg::S_TX;
					d.bitcnt = eeprom_slave_pkg::CNT_RST;
					d.shreg = rd_data_i;
					d.rd_req = 1'b1;
					d.oe_n = rd_data_i[7];
				end
			end
			default: begin
				d.st = eeprom_slave_pkg::S_STANDBY;
				d.oe_n = 1'b1;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// State register; reset acts at once, also on power-down

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			q <= '{meta: eeprom_slave_pkg::PINS_RST,
				sync: eeprom_slave_pkg::PINS_RST,
				scl_prev: 1'b1, sda_prev: 1'b1,
				st: eeprom_slave_pkg::S_STANDBY,
				bitcnt: eeprom_slave_pkg::CNT_RST,
				shreg: eeprom_slave_pkg::BYTE_RST,
				bytecnt: eeprom_slave_pkg::IDX_SELECT,
				rx_byte: eeprom_slave_pkg::BYTE_RST,
				rx_index: eeprom_slave_pkg::IDX_SELECT,
				oe_n: 1'b1, default: 1'b0};
		end else begin
			q <= d;
		end
	end

	// Every output comes straight from the state register
	assign sda_o = q.sda_out;
	assign sda_oe_n_o = q.oe_n;
	assign rd_req_o = q.rd_req;
	assign rx_byte_o = q.rx_byte;
	assign rx_valid_o = q.rx_valid;
	assign rx_index_o = q.rx_index;
	assign rnw_o = q.rnw;
	assign id_page_o = q.id_page;
	assign wr_start_o = q.wr_start;
	assign active_o = q.active;

	////////////////////////////////////////////////////////////////////
	// Checks

	// One clock domain, so clocking and disable are shared
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
		else $error("data pin driven high");
	AST_STANDBY_RELEASED: assert property (
		q.st == eeprom_slave_pkg::S_STANDBY |=> sda_oe_n_o)
		else $error("data pin held in standby");
	AST_STOP_STANDBY: assert property (
		stop_det |=> q.st == eeprom_slave_pkg::S_STANDBY ##1 !active_o)
		else $error("stop did not end transfer");
	AST_START_SEEN: assert property (
		start_det && !write_busy_i |=> q.st == eeprom_slave_pkg::S_RX &&
		q.bitcnt == 4'h0)
		else $error("start missed");
	AST_BUSY_DEAF: assert property (
		q.st == eeprom_slave_pkg::S_STANDBY && write_busy_i
		|=> q.st == eeprom_slave_pkg::S_STANDBY)
		else $error("start taken while busy");
	AST_SAMPLE_RISE: assert property (
		q.st == eeprom_slave_pkg::S_RX && scl_rise && !stop_det &&
		!start_det |=> q.shreg[0] == $past(q.sync.sda))
		else $error("bit not sampled on rise");
	AST_WP_NOACK: assert property (
		q.st == eeprom_slave_pkg::S_ACK_HOLD && q.bytecnt ==
		eeprom_slave_pkg::IDX_DATA && !q.rnw && $past(q.sync.wp, 3)
		&& q.sync.wp |-> sda_oe_n_o)
		else $error("protected data byte acknowledged");
	AST_MISMATCH: assert property (
		q.st == eeprom_slave_pkg::S_RX && scl_rise && !stop_det &&
		!start_det && q.bytecnt == 2'h0 && q.bitcnt == 4'h7 &&
		!cs_match |=> q.st == eeprom_slave_pkg::S_STANDBY [*2])
		else $error("foreign select answered");
	AST_ACK_LOW: assert property (
		q.st == eeprom_slave_pkg::S_ACK_HOLD |-> sda_oe_n_o == !q.ack)
		else $error("ack slot level wrong");
	AST_WR_LAUNCH: assert property (
		wr_start_o |-> $past(stop_det) && !$past(q.rnw))
		else $error("write launched without stop");
	AST_RNW: assert property (
		$rose(q.st == eeprom_slave_pkg::S_ACK_SET) && q.bytecnt == 2'h0
		&& !rx_valid_o |-> rnw_o == $past(q.sync.sda))
		else $error("direction bit wrong");

	COV_SELECT_ACK: cover property (
		q.st == eeprom_slave_pkg::S_ACK_HOLD && !sda_oe_n_o);
	COV_WRITE: cover property (wr_start_o);
	COV_READ: cover property (rd_req_o ##[1:1000] q.st ==
		eeprom_slave_pkg::S_RACK);
	COV_WP_REFUSE: cover property (
		q.st == eeprom_slave_pkg::S_ACK_HOLD && !q.ack);
endmodule : eeprom_slave
`default_nettype wire

/* File: tb/i2c_master_model.sv */
// Purpose: serial bus master that clocks the EEPROM slave front end
// Assumes: data line pulled up; one bit takes 12 system clocks (48 ns)
// Notes: serial clock rests high between frames
`default_nettype none
module i2c_master_model (
	input wire logic clk_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	// Master alone makes the clock
	assign scl_o = scl_q;
	assign sda_o = sda_q;
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask : tick
	////////////////////////////////////////////////////////////////////////
	// One pulse; data moves mid-low so it is stable over the rise
	task automatic bit_io(input logic b, output logic got);
		scl_q <= 1'b0;
		tick(3);
		sda_q <= b;
		tick(3);
		scl_q <= 1'b1;
		tick(5);
		got = sda_i;
		tick(1);
	endtask : bit_io
	// Caller always ends a frame with stop first, so no stray Stop here
	task automatic start();
		sda_q <= 1'b1;
		tick(6);
		sda_q <= 1'b0;
		tick(6);
	endtask : start
	task automatic stop();
		scl_q <= 1'b0;
		tick(3);
		sda_q <= 1'b0;
		tick(3);
		scl_q <= 1'b1;
		tick(6);
		sda_q <= 1'b1;
		tick(6);
	endtask : stop
	// Byte out MSB first, then release for the slave acknowledge
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], g);
		end
		bit_io(1'b1, g);
		ack = ~g;
	endtask : wbyte
	task automatic rbyte(input logic mack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, g);
			d[i] = g;
		end
		bit_io(~mack, g);
	endtask : rbyte
endmodule : i2c_master_model
`default_nettype wire

/* File: tb/eeprom_slave_tb.sv */
// Purpose: self-checking bench of the EEPROM slave front end
// Assumes: master model above; chip selects strapped to 5 then 0
// Notes: wire level is the AND of both parties on the pulled-up line
`default_nettype none
module eeprom_slave_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i, resetn_i, sda_o, sda_oe_n_o, m_scl, m_sda, sda_w, a;
	logic wp, busy, rd_req_o, rx_valid_o, rnw_o, id_page_o, wr_start_o;
	logic active_o;
	logic [2:0] cs, c;
	logic [3:0] nb;
	logic [7:0] rd_data, rx_byte_o, d;
	logic [1:0] rx_index_o;
	int fails = 0, checks_done = 0, wr_n = 0, n;
	int rd_n = 0, rv_n = 0, v;
	// Open drain: only a pull-down enable can lower the line
	assign sda_w = m_sda & (sda_oe_n_o | sda_o);
	eeprom_slave dut_u (.clk_i, .resetn_i, .scl_i(m_scl), .sda_i(sda_w),
		.sda_o, .sda_oe_n_o, .chip_select_input_high(cs[2]),
		.chip_select_input_mid(cs[1]), .chip_select_input_low(cs[0]),
		.write_protect_input(wp), .write_busy_i(busy),
		.rd_data_i(rd_data), .rd_req_o, .rx_byte_o, .rx_valid_o,
		.rx_index_o, .rnw_o, .id_page_o, .wr_start_o, .active_o);
	i2c_master_model m_u (.clk_i, .sda_i(sda_w), .scl_o(m_scl),
		.sda_o(m_sda));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Count launch pulses; a pulse stands one cycle only
	always @(posedge clk_i) begin
		if (wr_start_o === 1'b1) wr_n++;
		if (rd_req_o === 1'b1) rd_n++;
		if (rx_valid_o === 1'b1) rv_n++;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk1(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t bit got %b want %b", $time, g, e);
		end
	endtask : chk1
	task automatic chk8(input logic [7:0] g, input logic [7:0] e);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t byte got %h want %h", $time, g, e);
		end
	endtask : chk8
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	task automatic sel(input logic [3:0] t, input logic [2:0] e,
		input logic r, output logic ack);
		m_u.start();
		m_u.wbyte({t, e, r}, ack);
	endtask : sel
	// Whole run is some 20 us; hang guard well past that
	initial begin
		#100us;
		fails++;
		$display("[ERR] %0t watchdog expired", $time);
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		resetn_i = 1'b0;
		cs = 3'h5;
		wp = 1'b0;
		busy = 1'b0;
		rd_data = 8'h00;
		repeat (3) @(posedge clk_i);
		resetn_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk1(active_o, 1'b0);
		chk1(sda_oe_n_o, 1'b1);
		// Plain write, then the same write under protection
		for (int p = 0; p < 2; p++) begin
			wp <= p[0];
			n = wr_n;
			v = rv_n;
			sel(4'ha, 3'h5, 1'b0, a);
			chk1(a, 1'b1);
			chk1(rnw_o, 1'b0);
			m_u.wbyte(8'h12, a);
			chk1(a, 1'b1);
			chk8(rx_byte_o, 8'h12);
			m_u.wbyte(8'h34, a);
			m_u.wbyte(8'ha5, a);
			chk1(a, ~p[0]);
			chk8({6'h00, rx_index_o}, 8'h03);
			m_u.stop();
			repeat (4) @(posedge clk_i);
			chk1(wr_n != n, ~p[0]);
			chk1(rv_n == v + 3, 1'b1);
			chk1(active_o, 1'b0);
		end
		// Every type nibble, then every chip select code
		for (int t = 0; t < 24; t++) begin
			nb = (t < 16) ? t[3:0] : 4'ha;
			c = (t < 16) ? 3'h5 : t[2:0];
			sel(nb, c, 1'b0, a);
			chk1(a, nb[3:1] == 3'h5 && c == 3'h5);
			if (a === 1'b1) chk1(id_page_o, nb[0]);
			else chk1(active_o, 1'b0);
			m_u.stop();
		end
		// Read two bytes with selects strapped low; protect stays high
		cs <= 3'h0;
		rd_data <= 8'hc3;
		n = rd_n;
		sel(4'ha, 3'h0, 1'b1, a);
		chk1(a, 1'b1);
		chk1(rnw_o, 1'b1);
		m_u.rbyte(1'b1, d);
		rd_data <= 8'h3c;
		chk8(d, 8'hc3);
		m_u.rbyte(1'b0, d);
		chk8(d, 8'h3c);
		chk1(rd_n == n + 2, 1'b1);
		chk1(active_o, 1'b0);
		m_u.stop();
		chk1(sda_oe_n_o, 1'b1);
		// Start ignored while a write cycle runs
		busy <= 1'b1;
		sel(4'ha, 3'h0, 1'b0, a);
		chk1(a, 1'b0);
		m_u.stop();
		busy <= 1'b0;
		// Reset in mid-transfer silences the slave at once
		sel(4'ha, 3'h0, 1'b0, a);
		chk1(active_o, 1'b1);
		resetn_i <= 1'b0;
		@(posedge clk_i);
		chk1(active_o, 1'b0);
		m_u.wbyte(8'h00, a);
		chk1(a, 1'b0);
		resetn_i <= 1'b1;
		m_u.stop();
		// After the second release the slave answers again
		sel(4'ha, 3'h0, 1'b0, a);
		chk1(a, 1'b1);
		m_u.stop();
		end_of_test();
	end
endmodule : eeprom_slave_tb
`default_nettype wire
